/* design/dgc_filter.sv */
// Purpose: input synchroniser and software debounce for one input
// Assumes: sample_tick pulses once per sampling period
// Notes:   filter setting already clamped by the caller
`timescale 1ns/1ps
module dgc_filter
   import dgc_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   input  wire logic       pin_raw,
   input  wire logic       sample_tick,
   input  wire logic [7:0] filt_set,
   output logic            level_sync,
   output logic            level_filt
);

   logic       meta_q;
   logic [7:0] run_q;

   // --------------------------------------------------------------------
   // two stage synchroniser
   // --------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         meta_q     <= 1'b0;
         level_sync <= 1'b0;
      end else begin
         meta_q     <= pin_raw;
         level_sync <= meta_q;
      end
   end

   // --------------------------------------------------------------------
   // debounce: new level accepted only after it held for filt_set units
   // --------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         run_q      <= RST_BYTE;
         level_filt <= 1'b0;
      end else if (filt_set == RST_BYTE) begin
         run_q      <= RST_BYTE;
         level_filt <= level_sync;
      end else if (sample_tick) begin
         if (level_sync == level_filt) begin
            run_q <= RST_BYTE;
         end else if (run_q >= filt_set) begin
            run_q      <= RST_BYTE;
            level_filt <= level_sync;
         end else begin
            run_q <= 8'(run_q + FILT_STEP);
         end
      end
   end

endmodule

/* design/dgc_pkg.sv */
// Purpose: shared constants and types for the dual input event/gate counter
// Assumes: 40 MHz system clock
// Notes:   register offsets are byte addresses on the module register port
package dgc_pkg;

   // ----------------------------------------------------------------------
   // clocking and timing
   // ----------------------------------------------------------------------
   localparam longint CLK_HZ        = 40_000_000;
   localparam int     SAMPLE_US     = 200;
   localparam int     SAMPLE_CYC    = int'((SAMPLE_US * CLK_HZ) / 1_000_000);
   localparam int     FILT_UNIT_US  = 100;
   localparam int     FILT_STEP_I   = SAMPLE_US / FILT_UNIT_US;
   localparam logic [7:0] FILT_STEP = 8'(FILT_STEP_I);
   localparam logic [7:0] FILT_MAX  = 8'h00_FA;
   localparam int     GATE_FRAC     = 24;

   // ----------------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------------
   localparam logic [7:0] OFS_INPUT_LEVELS   = 8'h00;
   localparam logic [7:0] OFS_FIRST_COUNT    = 8'h04;
   localparam logic [7:0] OFS_SECOND_COUNT   = 8'h06;
   localparam logic [7:0] OFS_FILTER_TIME    = 8'h12;
   localparam logic [7:0] OFS_FIRST_SETUP    = 8'h14;
   localparam logic [7:0] OFS_SECOND_SETUP   = 8'h16;
   localparam logic [7:0] OFS_LATCHED_RISE   = 8'h1A;
   localparam logic [7:0] OFS_LATCH_ACK      = 8'h1C;

   // ----------------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------------
   localparam int SETUP_SEL_LSB  = 0;
   localparam int SETUP_SEL_MSB  = 3;
   localparam int SETUP_CLR_BIT  = 5;
   localparam int SETUP_MODE_LSB = 6;
   localparam int SETUP_MODE_MSB = 7;
   localparam logic [7:0]  RST_BYTE    = 8'h00;
   localparam logic [15:0] RST_COUNT   = 16'h0000;
   localparam logic [15:0] GATE_OVFL   = 16'hFFFF;
   localparam logic [1:0]  MODE_EVENT  = 2'h0;
   localparam logic [1:0]  MODE_GATE   = 2'h1;
   localparam logic [3:0]  SEL_SW_EVT  = 4'h1;
   localparam logic [7:0]  ANALOG_SLOTS = 8'h01;

   // ----------------------------------------------------------------------
   // gate clock phase steps, fraction of GATE_FRAC bits per system clock
   // ----------------------------------------------------------------------
   localparam logic [25:0] STEP_48M  = 26'((64'd48_000_000 << GATE_FRAC) / CLK_HZ);
   localparam logic [25:0] STEP_24M  = 26'((64'd24_000_000 << GATE_FRAC) / CLK_HZ);
   localparam logic [25:0] STEP_12M  = 26'((64'd12_000_000 << GATE_FRAC) / CLK_HZ);
   localparam logic [25:0] STEP_6M   = 26'((64'd6_000_000 << GATE_FRAC) / CLK_HZ);
   localparam logic [25:0] STEP_3M   = 26'((64'd3_000_000 << GATE_FRAC) / CLK_HZ);
   localparam logic [25:0] STEP_1M5  = 26'((64'd1_500_000 << GATE_FRAC) / CLK_HZ);
   localparam logic [25:0] STEP_750K = 26'((64'd750_000 << GATE_FRAC) / CLK_HZ);
   localparam logic [25:0] STEP_375K = 26'((64'd375_000 << GATE_FRAC) / CLK_HZ);
   localparam logic [25:0] STEP_188K =
      26'((64'd375_000 << (GATE_FRAC - 1)) / CLK_HZ);

   // ----------------------------------------------------------------------
   // types
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [7:0]  addr;
      logic [15:0] wdata;
   } dgc_req_s;

   typedef struct packed {
      logic        valid;
      logic [15:0] rdata;
   } dgc_rsp_s;

   typedef enum logic [0:0] {
      GATE_IDLE = 1'b0,
      GATE_RUN  = 1'b1
   } dgc_gate_e;

   // clock select code to phase step; unlisted codes run at 48 MHz
   function automatic logic [25:0] gate_step(input logic [3:0] sel);
      unique case (sel)
         4'h1:    gate_step = STEP_3M;
         4'h2:    gate_step = STEP_188K;
         4'h3:    gate_step = STEP_24M;
         4'h4:    gate_step = STEP_12M;
         4'h5:    gate_step = STEP_6M;
         4'h6:    gate_step = STEP_1M5;
         4'h7:    gate_step = STEP_750K;
         4'h8:    gate_step = STEP_375K;
         default: gate_step = STEP_48M;
      endcase
   endfunction

   function automatic logic [7:0] clamp_filter(input logic [7:0] v);
      clamp_filter = (v > FILT_MAX) ? FILT_MAX : v;
   endfunction

   function automatic logic [15:0] sat_add(input logic [15:0] a,
                                           input logic [1:0]  b);
      logic [16:0] s;
      s = {1'b0, a} + {15'h0000, b};
      sat_add = s[16] ? GATE_OVFL : s[15:0];
   endfunction

endpackage

/* design/dgc_top.sv */
// Purpose: two-input event counter, gate measurement, filter and latches
// Assumes: req and net_cycle come from bus controller logic on clk_sys
// Notes:   read answers appear one clock after the read request
`timescale 1ns/1ps
module dgc_top
   import dgc_pkg::*;
#(
   parameter int SAMPLE_CYCLES = SAMPLE_CYC,
   parameter int CNT_W         = 16
)(
   input  wire logic             clk_sys,
   input  wire logic             rst_b,
   input  wire logic [1:0]       pin_in,
   input  wire logic             net_cycle,
   input  wire dgc_req_s         req,
   output dgc_rsp_s              rsp,
   output logic [31:0]           can_object,
   output logic [7:0]            analog_slots,
   output logic [1:0]            led_input
);

   logic [15:0]      tick_cnt_q;
   logic             sample_tick_q;
   logic [7:0]       filt_time_q;
   logic [7:0]       setup_q [2];
   logic [1:0]       ack_q;
   logic [1:0]       lvl_sync;
   logic [1:0]       lvl_filt;
   logic [1:0]       sync_prev_q;
   logic [1:0]       filt_prev_q;
   logic [1:0]       latch_q;
   logic [CNT_W-1:0] cnt_q [2];
   logic [1:0]       snap_raw_q;
   logic [1:0]       snap_filt_q;
   logic [1:0]       snap_latch_q;
   logic [1:0]       level_rep;
   logic [CNT_W-1:0] snap_cnt_q [2];
   dgc_gate_e        gate_q;
   logic [15:0]      gate_cnt_q;
   logic [GATE_FRAC-1:0] gate_acc_q;
   logic [1:0]       gate_en;
   logic             gate_ch;
   logic             gate_rise;
   logic             gate_fall;
   logic [1:0]       clr_pulse;
   logic [1:0]       evt_edge;
   logic [GATE_FRAC+1:0] gate_sum;

   // ----------------------------------------------------------------------
   // setup field decode and edge detect
   // ----------------------------------------------------------------------
   function automatic logic [3:0] sel_of(input logic [7:0] setup);
      sel_of = setup[SETUP_SEL_MSB:SETUP_SEL_LSB];
   endfunction

   function automatic logic [1:0] mode_of(input logic [7:0] setup);
      mode_of = setup[SETUP_MODE_MSB:SETUP_MODE_LSB];
   endfunction

   function automatic logic edge_up(input logic now, input logic was);
      edge_up = now && !was;
   endfunction

   // ----------------------------------------------------------------------
   // sampling grid and input filters
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         tick_cnt_q    <= 16'h0000;
         sample_tick_q <= 1'b0;
      end else if (tick_cnt_q == 16'(SAMPLE_CYCLES - 1)) begin
         tick_cnt_q    <= 16'h0000;
         sample_tick_q <= 1'b1;
      end else begin
         tick_cnt_q    <= 16'(tick_cnt_q + 16'h0001);
         sample_tick_q <= 1'b0;
      end
   end

   for (genvar i = 0; i < 2; i++) begin : g_in
      dgc_filter u_filter (
         .clk_sys     (clk_sys),
         .rst_b       (rst_b),
         .pin_raw     (pin_in[i]),
         .sample_tick (sample_tick_q),
         .filt_set    (clamp_filter(filt_time_q)),
         .level_sync  (lvl_sync[i]),
         .level_filt  (lvl_filt[i])
      );
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         sync_prev_q <= 2'h0;
         filt_prev_q <= 2'h0;
      end else begin
         sync_prev_q <= lvl_sync;
         filt_prev_q <= lvl_filt;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         led_input <= 2'h0;
      end else begin
         led_input <= lvl_sync;
      end
   end

   // ----------------------------------------------------------------------
   // configuration writes
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         filt_time_q <= RST_BYTE;
         setup_q[0]  <= RST_BYTE;
         setup_q[1]  <= RST_BYTE;
         ack_q       <= 2'h0;
      end else if (req.wr) begin
         unique case (req.addr)
            OFS_FILTER_TIME: filt_time_q <= req.wdata[7:0];
            OFS_FIRST_SETUP: setup_q[0]  <= req.wdata[7:0];
            OFS_SECOND_SETUP: setup_q[1] <= req.wdata[7:0];
            OFS_LATCH_ACK:   ack_q       <= req.wdata[1:0];
            default: ;
         endcase
      end
   end

   always_comb begin
      clr_pulse[0] = req.wr && req.addr == OFS_FIRST_SETUP
                     && req.wdata[SETUP_CLR_BIT]
                     && !setup_q[0][SETUP_CLR_BIT];
      clr_pulse[1] = req.wr && req.addr == OFS_SECOND_SETUP
                     && req.wdata[SETUP_CLR_BIT]
                     && !setup_q[1][SETUP_CLR_BIT];
   end

   // ----------------------------------------------------------------------
   // mode decode; channel one wins if both ask for gate mode
   // ----------------------------------------------------------------------
   always_comb begin
      gate_en[0] = mode_of(setup_q[0]) == MODE_GATE;
      gate_en[1] = mode_of(setup_q[1]) == MODE_GATE
                   && !gate_en[0];
      gate_ch    = gate_en[1];
      gate_rise  = (gate_en != 2'h0)
                   && edge_up(lvl_sync[gate_ch], sync_prev_q[gate_ch]);
      gate_fall  = (gate_en != 2'h0)
                   && edge_up(sync_prev_q[gate_ch], lvl_sync[gate_ch]);
      for (int i = 0; i < 2; i++) begin
         if (sel_of(setup_q[i]) == SEL_SW_EVT) begin
            evt_edge[i] = edge_up(lvl_filt[i], filt_prev_q[i]);
         end else begin
            evt_edge[i] = edge_up(lvl_sync[i], sync_prev_q[i]);
         end
      end
      gate_sum = {2'b00, gate_acc_q} + gate_step(sel_of(setup_q[gate_ch]));
   end

   // ----------------------------------------------------------------------
   // gate measurement timebase
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         gate_q     <= GATE_IDLE;
         gate_cnt_q <= RST_COUNT;
         gate_acc_q <= '0;
      end else if (gate_en == 2'h0) begin
         gate_q <= GATE_IDLE;
      end else begin
         unique case (gate_q)
            GATE_IDLE: begin
               if (gate_rise) begin
                  gate_q     <= GATE_RUN;
                  gate_cnt_q <= RST_COUNT;
                  gate_acc_q <= '0;
               end
            end
            GATE_RUN: begin
               gate_acc_q <= gate_sum[GATE_FRAC-1:0];
               gate_cnt_q <= sat_add(gate_cnt_q,
                                     gate_sum[GATE_FRAC+1:GATE_FRAC]);
               if (gate_fall) begin
                  gate_q <= GATE_IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // counters
   // ----------------------------------------------------------------------
   for (genvar i = 0; i < 2; i++) begin : g_cnt
      always_ff @(posedge clk_sys) begin
         if (!rst_b) begin
            cnt_q[i] <= RST_COUNT;
         end else if (clr_pulse[i]) begin
            cnt_q[i] <= RST_COUNT;
         end else if (gate_en[i]) begin
            if (gate_q == GATE_RUN && gate_fall) begin
               cnt_q[i] <= gate_cnt_q;
            end
         end else if (evt_edge[i]) begin
            cnt_q[i] <= CNT_W'(cnt_q[i] + 1'b1);
         end
      end
   end

   // ----------------------------------------------------------------------
   // rise latches, acknowledge dominant
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         latch_q <= 2'h0;
      end else begin
         latch_q <= ~ack_q & (latch_q | (lvl_filt & ~filt_prev_q));
      end
   end

   // ----------------------------------------------------------------------
   // network cycle snapshot
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         snap_raw_q    <= 2'h0;
         snap_filt_q   <= 2'h0;
         snap_latch_q  <= 2'h0;
         snap_cnt_q[0] <= RST_COUNT;
         snap_cnt_q[1] <= RST_COUNT;
         can_object    <= 32'h0000_0000;
      end else if (net_cycle) begin
         snap_raw_q    <= lvl_sync;
         snap_filt_q   <= lvl_filt;
         snap_latch_q  <= latch_q;
         snap_cnt_q[0] <= cnt_q[0];
         snap_cnt_q[1] <= cnt_q[1];
         can_object    <= {cnt_q[1], cnt_q[0]};
      end
   end

   // with filtering on the host sees the debounced level
   always_comb begin
      level_rep = (filt_time_q == RST_BYTE)
                  ? snap_raw_q
                  : snap_filt_q;
   end

   // ----------------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rsp <= '0;
      end else begin
         rsp.valid <= req.rd;
         rsp.rdata <= 16'h0000;
         if (req.rd) begin
            unique case (req.addr)
               OFS_INPUT_LEVELS: rsp.rdata <= {14'h0000, level_rep};
               OFS_FIRST_COUNT:  rsp.rdata <= snap_cnt_q[0];
               OFS_SECOND_COUNT: rsp.rdata <= snap_cnt_q[1];
               OFS_LATCHED_RISE: rsp.rdata <= {14'h0000, snap_latch_q};
               default:          rsp.rdata <= 16'h0000;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         analog_slots <= RST_BYTE;
      end else begin
         analog_slots <= ANALOG_SLOTS;
      end
   end

endmodule

/* dv/dgc_host_model.sv */
// Purpose: bus controller model issuing register access and cycle strobes
// Assumes: requests change only on the falling edge of clk_sys
// Notes:   read answer taken at the falling edge after the request edge
`timescale 1ns/1ps
module dgc_host_model
   import dgc_pkg::*;
(
   input  wire logic     clk_sys,
   input  wire dgc_rsp_s rsp,
   output dgc_req_s      req,
   output logic          net_cycle
);
   initial begin
      req       = '0;
      net_cycle = 1'b0;
   end

   // ------------------------------------------------------------
   // access tasks
   // ------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk_sys);
      req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(negedge clk_sys);
      req = '0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [15:0] d,
                     output logic v);
      @(negedge clk_sys);
      req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
      @(negedge clk_sys);
      v   = rsp.valid;
      d   = rsp.rdata;
      req = '0;
   endtask

   // one-cycle network strobe
   task automatic cyc();
      @(negedge clk_sys);
      net_cycle = 1'b1;
      @(negedge clk_sys);
      net_cycle = 1'b0;
   endtask
endmodule

/* dv/dgc_top_chk.sv */
// Purpose: port-level assertions for the dual input counter block
// Assumes: single clk_sys domain, synchronous active-low rst_b
// Notes:   bound to every dgc_top instance
`timescale 1ns/1ps
module dgc_top_chk
   import dgc_pkg::*;
#(
   parameter int SAMPLE_CYCLES = SAMPLE_CYC,
   parameter int CNT_W         = 16
)(
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic [1:0]  pin_in,
   input  wire logic        net_cycle,
   input  wire dgc_req_s    req,
   input  wire dgc_rsp_s    rsp,
   input  wire logic [31:0] can_object,
   input  wire logic [7:0]  analog_slots,
   input  wire logic [1:0]  led_input
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   // ------------------------------------------------------------
   // register port and snapshot relations
   // ------------------------------------------------------------
   a_rd_answer: assert property (req.rd |=> rsp.valid)
      else $error("read not answered one cycle later");
   a_valid_cause: assert property (rsp.valid |-> $past(req.rd))
      else $error("answer without a read");
   a_idle_rdata: assert property (!rsp.valid |-> rsp.rdata == 16'h0000)
      else $error("read data not zero while idle");
   a_ack_reads_zero: assert property (
      req.rd && req.addr == OFS_LATCH_ACK |=> rsp.rdata == 16'h0000)
      else $error("acknowledge byte read back nonzero");
   a_level_bits: assert property (
      req.rd && req.addr == OFS_INPUT_LEVELS |=> rsp.rdata[15:2] == 14'h0000)
      else $error("input level upper bits set");
   a_slots_one: assert property (
      $past(rst_b) |-> analog_slots == ANALOG_SLOTS)
      else $error("slot count wrong");
   a_can_steady: assert property (
      !$past(net_cycle) |-> $stable(can_object))
      else $error("bus object changed between cycles");
   a_obj_first: assert property (
      req.rd && req.addr == OFS_FIRST_COUNT && !net_cycle
      |=> rsp.rdata == can_object[15:0])
      else $error("first count differs from bus object");
   a_obj_second: assert property (
      req.rd && req.addr == OFS_SECOND_COUNT && !net_cycle
      |=> rsp.rdata == can_object[31:16])
      else $error("second count differs from bus object");
   a_led_follow: assert property (
      ($past(rst_b, 6) && $stable(pin_in))[*5] |-> led_input == pin_in)
      else $error("indicator does not follow input");
endmodule

bind dgc_top dgc_top_chk #(
   .SAMPLE_CYCLES(SAMPLE_CYCLES),
   .CNT_W        (CNT_W)
) u_chk (
   .clk_sys(clk_sys), .rst_b(rst_b), .pin_in(pin_in),
   .net_cycle(net_cycle), .req(req), .rsp(rsp),
   .can_object(can_object), .analog_slots(analog_slots),
   .led_input(led_input)
);

/* dv/tb_top.sv */
// Purpose: self-checking bench for the dual input counter block
// Assumes: sampling grid shortened to 8 clocks
// Notes:   inputs change on the falling clock edge only
`timescale 1ns/1ps
module tb_top
   import dgc_pkg::*;
;
   logic        clk_sys;
   logic        rst_b;
   logic [1:0]  pin_in;
   dgc_req_s    req;
   dgc_rsp_s    rsp;
   logic        net_cycle;
   logic [31:0] can_object;
   logic [7:0]  analog_slots;
   logic [1:0]  led_input;
   logic [15:0] rdat;
   logic        rv;
   int          err_count;
   int          n_tests;

   dgc_top #(.SAMPLE_CYCLES(8)) dut (
      .clk_sys(clk_sys), .rst_b(rst_b), .pin_in(pin_in),
      .net_cycle(net_cycle), .req(req), .rsp(rsp),
      .can_object(can_object), .analog_slots(analog_slots),
      .led_input(led_input));
   dgc_host_model u_host (
      .clk_sys(clk_sys), .rsp(rsp), .req(req), .net_cycle(net_cycle));

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rdc(input string nm, input logic [7:0] a,
                      input logic [15:0] e);
      u_host.rd(a, rdat, rv);
      chk({nm, " valid"}, 16'h0001, {15'h0000, rv});
      chk(nm, e, rdat);
   endtask

   task automatic pulse(input int ch, input int hi, input int lo);
      @(negedge clk_sys);
      pin_in[ch] = 1'b1;
      repeat (hi) @(negedge clk_sys);
      pin_in[ch] = 1'b0;
      repeat (lo) @(negedge clk_sys);
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      rdc("count one", OFS_FIRST_COUNT, RST_COUNT);
      rdc("count two", OFS_SECOND_COUNT, RST_COUNT);
      rdc("rise flags", OFS_LATCHED_RISE, 16'h0000);
      rdc("filter wo", OFS_FILTER_TIME, 16'h0000);
      rdc("ack wo", OFS_LATCH_ACK, 16'h0000);
      rdc("unmapped", 8'h30, 16'h0000);
      chk("slots", 16'(ANALOG_SLOTS), {8'h00, analog_slots});
      $display("t_reset done");
   endtask

   task automatic t_levels();
      pin_in = 2'b10;
      repeat (6) @(negedge clk_sys);
      chk("led", 16'h0002, {14'h0000, led_input});
      u_host.cyc();
      rdc("levels two", OFS_INPUT_LEVELS, 16'h0002);
      pin_in = 2'b01;
      repeat (6) @(negedge clk_sys);
      u_host.cyc();
      rdc("levels one", OFS_INPUT_LEVELS, 16'h0001);
      pin_in = 2'b00;
      repeat (6) @(negedge clk_sys);
      u_host.wr(OFS_FIRST_SETUP, 16'h0020);
      u_host.wr(OFS_FIRST_SETUP, 16'h0000);
      u_host.wr(OFS_SECOND_SETUP, 16'h0020);
      u_host.wr(OFS_SECOND_SETUP, 16'h0000);
      $display("t_levels done");
   endtask

   task automatic t_event();
      for (int i = 0; i < 5; i++) pulse(0, 4, 4);
      u_host.cyc();
      rdc("count one", OFS_FIRST_COUNT, 16'h0005);
      chk("obj one", 16'h0005, can_object[15:0]);
      chk("obj two", 16'h0000, can_object[31:16]);
      u_host.wr(OFS_FIRST_SETUP, 16'h0020);
      u_host.cyc();
      rdc("cleared", OFS_FIRST_COUNT, 16'h0000);
      u_host.wr(OFS_FIRST_SETUP, 16'h0000);
      $display("t_event done");
   endtask

   task automatic t_filter();
      u_host.wr(OFS_FILTER_TIME, 16'h0004);
      u_host.wr(OFS_SECOND_SETUP, 16'(SEL_SW_EVT));
      pin_in[1] = 1'b1;
      repeat (4) @(negedge clk_sys);
      u_host.cyc();
      rdc("filt level", OFS_INPUT_LEVELS, 16'h0000);
      pin_in[1] = 1'b0;
      repeat (16) @(negedge clk_sys);
      pulse(1, 6, 40);
      pulse(1, 40, 40);
      u_host.cyc();
      rdc("filt count", OFS_SECOND_COUNT, 16'h0001);
      u_host.wr(OFS_SECOND_SETUP, 16'h0000);
      pulse(1, 6, 40);
      u_host.cyc();
      rdc("raw count", OFS_SECOND_COUNT, 16'h0002);
      rdc("flags", OFS_LATCHED_RISE, 16'h0003);
      u_host.wr(OFS_LATCH_ACK, 16'h0003);
      pulse(1, 40, 40);
      u_host.cyc();
      rdc("ack held", OFS_LATCHED_RISE, 16'h0000);
      u_host.wr(OFS_LATCH_ACK, 16'h0000);
      u_host.wr(OFS_SECOND_SETUP, 16'(SEL_SW_EVT));
      pulse(1, 40, 40);
      u_host.cyc();
      rdc("flag two", OFS_LATCHED_RISE, 16'h0002);
      u_host.wr(OFS_FILTER_TIME, 16'h00FF);
      pulse(1, 900, 40);
      pulse(1, 1016, 40);
      u_host.cyc();
      rdc("clamp count", OFS_SECOND_COUNT, 16'h0005);
      u_host.wr(OFS_FILTER_TIME, 16'h0000);
      u_host.wr(OFS_SECOND_SETUP, 16'h0000);
      $display("t_filter done");
   endtask

   task automatic t_gate();
      int g[9] = '{960, 60, 3, 480, 240, 120, 30, 15, 7};
      logic [15:0] lo;
      logic [15:0] hi;
      for (int s = 0; s < 9; s++) begin
         u_host.wr(OFS_FIRST_SETUP, 16'(8'h40 + s));
         pulse(0, 800, 4000);
         u_host.cyc();
         u_host.rd(OFS_FIRST_COUNT, rdat, rv);
         chk("gate valid", 16'h0001, {15'h0000, rv});
         lo = 16'(g[s] - 2);
         hi = 16'(g[s] + 2);
         n_tests++;
         if ((rdat >= lo && rdat <= hi) !== 1'b1) begin
            err_count++;
            $display("MISMATCH gate count expected %0d seen %0d", g[s], rdat);
         end
      end
      u_host.wr(OFS_FIRST_SETUP, 16'h0040);
      pulse(0, 54800, 200);
      u_host.cyc();
      rdc("gate ovfl", OFS_FIRST_COUNT, GATE_OVFL);
      chk("obj ovfl", GATE_OVFL, can_object[15:0]);
      $display("t_gate done");
   endtask

   initial begin
      #(25ns * 110000);
      err_count++;
      $display("MISMATCH watchdog expected end seen hang");
      finish_test();
   end

   initial begin
      err_count = 0;
      n_tests   = 0;
      rst_b     = 1'b0;
      pin_in    = 2'b00;
      repeat (8) @(negedge clk_sys);
      rst_b = 1'b1;
      @(negedge clk_sys);
      t_reset();
      t_levels();
      t_event();
      t_filter();
      t_gate();
      finish_test();
   end
endmodule
